/* File: hw/tsmie_defs.vh */
// constants of the slave-mode controller and interrupt/dma enable bank
//
// Overview of operation
// - trigger source code 0-3 picks master links, 4 ch1 edge, 5/6 filtered, 7 external
// - switch-select bit picks external input (0) or output-off signal (1) to clear outputs
// - slave mode 000 disables slave behaviour; trigger input leaves counter alone
// - reset mode 100: each trigger rising edge reinitializes the counter
// - suspend mode 101: counter advances only while trigger input is high
// - trigger mode 110: trigger rising edge raises a trigger event that starts counter
// - external clock mode 111: each trigger rising edge advances counter one step
// - enable bit 14 gates trigger dma request, resets to 0
// - enable bit 13 gates commutation dma request, resets to 0
// - enable bits 12..9 gate channel 4..1 dma requests, reset to 0
// - enable bit 8 gates overflow dma request, resets to 0
// - enable low byte gates break, trigger, commutation, ch4..1, overflow interrupts
// - enable bit 15 is reserved and reads as 0
// - trigger event is an active trigger edge, or any edge in suspend mode
// - commutation event is the load of buffered channel enable and control bits
`ifndef TSMIE_DEFS_VH
`define TSMIE_DEFS_VH

`define TSMIE_ADDR_STC       12'h000
`define TSMIE_ADDR_IDEN      12'h004
`define TSMIE_ADDR_STS       12'h008
`define TSMIE_ADDR_CTRL      12'h00c
`define TSMIE_ADDR_PERIOD    12'h010
`define TSMIE_ADDR_COUNT     12'h014

`define TSMIE_STC_MASK       16'h007f
`define TSMIE_IDEN_MASK      16'h7fff
`define TSMIE_STS_MASK       8'hff
`define TSMIE_PERIOD_RST     16'hffff

`define TSMIE_SMS_LSB        0
`define TSMIE_SMS_MSB        2
`define TSMIE_COSW_BIT       3
`define TSMIE_TIS_LSB        4
`define TSMIE_TIS_MSB        6
`define TSMIE_CTRL_EN_BIT    0

`define TSMIE_EV_OVF         0
`define TSMIE_EV_CH_LSB      1
`define TSMIE_EV_CH_MSB      4
`define TSMIE_EV_COMM        5
`define TSMIE_EV_TRIG        6
`define TSMIE_EV_BRK         7
`define TSMIE_DMA_LSB        8
`define TSMIE_DMA_MSB        14

`define TSMIE_SM_OFF         3'h0
`define TSMIE_SM_ENC_A       3'h1
`define TSMIE_SM_ENC_B       3'h2
`define TSMIE_SM_ENC_C       3'h3
`define TSMIE_SM_RESET       3'h4
`define TSMIE_SM_SUSPEND     3'h5
`define TSMIE_SM_TRIGGER     3'h6
`define TSMIE_SM_EXTCLK      3'h7

`define TSMIE_TIS_CH1EDGE    3'h4
`define TSMIE_TIS_FILT1      3'h5
`define TSMIE_TIS_FILT2      3'h6
`define TSMIE_TIS_EXT        3'h7

`define TSMIE_SYNC_W         4
`define TSMIE_PIN_EXT        0
`define TSMIE_PIN_BRK        1
`define TSMIE_PIN_ENCA       2
`define TSMIE_PIN_ENCB       3

`endif

/* File: hw/tsmie_pin_sync.v */
// three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module tsmie_pin_sync #(
  parameter WIDTH = 4
) (
  input  wire             core_clk, // kernel clock
  input  wire             rst_n,    // async reset, active low
  input  wire [WIDTH-1:0] pinIn,    // raw asynchronous pins
  output reg  [WIDTH-1:0] pinOut    // accepted level
);
  reg [WIDTH-1:0] stageOne;
  reg [WIDTH-1:0] stageTwo;
  reg [WIDTH-1:0] stageThree;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stageOne[i]   <= 1'b0;
          stageTwo[i]   <= 1'b0;
          stageThree[i] <= 1'b0;
          pinOut[i]     <= 1'b0;
        end else begin
          stageOne[i]   <= pinIn[i];
          stageTwo[i]   <= stageOne[i];
          stageThree[i] <= stageTwo[i];
          // a one-cycle glitch past stage one never reaches the output
          if (stageTwo[i] == stageThree[i]) begin
            pinOut[i] <= stageThree[i];
          end
        end
      end
    end
  endgenerate
endmodule // tsmie_pin_sync
`default_nettype wire

/* File: hw/tsmie_slave_timer.v */
// slave-mode controller, 16-bit counter and interrupt/dma enable bank with apb access
`timescale 1ns/10ps
`default_nettype none
`include "tsmie_defs.vh"
module tsmie_slave_timer (
  input  wire        core_clk,                 // kernel clock, 250 mhz
  input  wire        rst_n,                    // async reset, active low
  input  wire        psel,                     // apb select
  input  wire        penable,                  // apb access phase
  input  wire        pwrite,                   // apb direction
  input  wire [11:0] paddr,                    // apb byte address
  input  wire [31:0] pwdata,                   // apb write data
  output reg  [31:0] prdata,                   // apb read data
  output reg         pready,                   // apb ready
  output reg         pslverr,                  // apb error, unmapped address
  input  wire [3:0]  internalMasterSel,        // master timer links 0..3
  input  wire        ch1EdgeDetector,          // channel 1 raw edge detector
  input  wire        filteredInputOne,         // filtered channel input 1
  input  wire        filteredInputTwo,         // filtered channel input 2
  input  wire        externalTriggerInput,     // external trigger pin
  input  wire        breakInput,               // break pin, active high
  input  wire        encoderInA,               // quadrature pin a
  input  wire        encoderInB,               // quadrature pin b
  input  wire [3:0]  channelEvent,             // channel 4..1 compare/capture pulses
  input  wire        commutationLoad,          // buffered enables copied to active
  input  wire [3:0]  channelRawCompareOutput,  // raw compare outputs 4..1
  input  wire        channelOutputOffSignal,   // dedicated output-off signal
  output reg  [3:0]  channelCompareOutput,     // compare outputs after clearing
  output reg  [15:0] counterValue,             // counter value
  output reg         slaveTriggerInput,        // selected trigger, registered
  output reg         irq,                      // level interrupt
  output reg  [6:0]  dmaRequest                // ovf, ch1..4, commutation, trigger
);
  reg  [15:0] slaveTriggerControl;
  reg  [15:0] interruptDmaEnable;
  reg  [7:0]  eventStatus;
  reg         counterEnable;
  reg  [15:0] periodValue;
  reg         trigPrev;
  reg         encAPrev;
  reg         encBPrev;
  reg  [15:0] next_counterValue;
  reg         next_counterEnable;
  reg         next_overflow;
  reg         next_trigEvent;
  reg         next_trigSel;
  reg         stepUp;
  reg         stepDown;
  reg  [31:0] next_prdata;
  reg         next_pslverr;

  wire [`TSMIE_SYNC_W-1:0] pinSync;
  wire [2:0] slaveModeSelect    = slaveTriggerControl[`TSMIE_SMS_MSB:`TSMIE_SMS_LSB];
  wire [2:0] triggerSourceSelect = slaveTriggerControl[`TSMIE_TIS_MSB:`TSMIE_TIS_LSB];
  wire       outputClearSwitchSelect = slaveTriggerControl[`TSMIE_COSW_BIT];
  wire       extSync = pinSync[`TSMIE_PIN_EXT];
  wire       brkSync = pinSync[`TSMIE_PIN_BRK];
  wire       encA    = pinSync[`TSMIE_PIN_ENCA];
  wire       encB    = pinSync[`TSMIE_PIN_ENCB];
  wire       apbAccess = psel & penable & pready;
  wire       apbWrite  = apbAccess & pwrite;
  wire [7:0] eventNow;

  // true when the apb address hits the given register word
  function hit;
    input [11:0] addr;
    input [11:0] reg_addr;
    begin
      hit = (addr == reg_addr);
    end
  endfunction

  tsmie_pin_sync #(
    .WIDTH(`TSMIE_SYNC_W)
  ) uPinSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    ({encoderInB, encoderInA, breakInput, externalTriggerInput}),
    .pinOut   (pinSync)
  );

  // trigger source selection
  always @* begin
    if (triggerSourceSelect == `TSMIE_TIS_EXT) begin
      next_trigSel = extSync;
    end else if (triggerSourceSelect == `TSMIE_TIS_FILT2) begin
      next_trigSel = filteredInputTwo;
    end else if (triggerSourceSelect == `TSMIE_TIS_FILT1) begin
      next_trigSel = filteredInputOne;
    end else if (triggerSourceSelect == `TSMIE_TIS_CH1EDGE) begin
      next_trigSel = ch1EdgeDetector;
    end else begin
      next_trigSel = internalMasterSel[triggerSourceSelect[1:0]];
    end
  end

  wire trigRise = slaveTriggerInput & ~trigPrev;
  wire trigAny  = slaveTriggerInput ^ trigPrev;

  // quadrature steps: a counts on b edges, b on a edges, c on both
  always @* begin
    stepUp   = 1'b0;
    stepDown = 1'b0;
    if ((slaveModeSelect == `TSMIE_SM_ENC_A) || (slaveModeSelect == `TSMIE_SM_ENC_C)) begin
      if (encB != encBPrev) begin
        stepUp   = (encB ^ encA);
        stepDown = ~(encB ^ encA);
      end
    end
    if ((slaveModeSelect == `TSMIE_SM_ENC_B) || (slaveModeSelect == `TSMIE_SM_ENC_C)) begin
      if (encA != encAPrev) begin
        stepUp   = ~(encA ^ encB);
        stepDown = encA ^ encB;
      end
    end
  end

  // counter and slave mode behaviour
  always @* begin
    next_counterValue  = counterValue;
    next_counterEnable = counterEnable;
    next_overflow      = 1'b0;
    next_trigEvent     = 1'b0;
    if (apbWrite && hit(paddr, `TSMIE_ADDR_CTRL)) begin
      next_counterEnable = pwdata[`TSMIE_CTRL_EN_BIT];
    end
    // suspend mode treats either edge as a trigger event, others the rising one
    if (slaveModeSelect == `TSMIE_SM_SUSPEND) begin
      next_trigEvent = trigAny;
    end else begin
      next_trigEvent = trigRise;
    end
    case (slaveModeSelect)
      `TSMIE_SM_OFF: begin
        // slave behaviour off: the trigger only flags events, never touches the count
        next_counterEnable = next_counterEnable;
      end
      `TSMIE_SM_TRIGGER: begin
        if (trigRise) begin
          next_counterEnable = 1'b1;
        end
      end
      default: begin
        next_counterEnable = next_counterEnable;
      end
    endcase
    if (counterEnable) begin
      case (slaveModeSelect)
        `TSMIE_SM_ENC_A, `TSMIE_SM_ENC_B, `TSMIE_SM_ENC_C: begin
          if (stepUp) begin
            if (counterValue == periodValue) begin
              next_counterValue = 16'h0000;
              next_overflow     = 1'b1;
            end else begin
              next_counterValue = counterValue + 16'h0001;
            end
          end else if (stepDown) begin
            if (counterValue == 16'h0000) begin
              next_counterValue = periodValue;
              next_overflow     = 1'b1;
            end else begin
              next_counterValue = counterValue - 16'h0001;
            end
          end
        end
        `TSMIE_SM_SUSPEND: begin
          if (slaveTriggerInput) begin
            if (counterValue == periodValue) begin
              next_counterValue = 16'h0000;
              next_overflow     = 1'b1;
            end else begin
              next_counterValue = counterValue + 16'h0001;
            end
          end
        end
        `TSMIE_SM_EXTCLK: begin
          if (trigRise) begin
            if (counterValue == periodValue) begin
              next_counterValue = 16'h0000;
              next_overflow     = 1'b1;
            end else begin
              next_counterValue = counterValue + 16'h0001;
            end
          end
        end
        default: begin
          if (counterValue == periodValue) begin
            next_counterValue = 16'h0000;
            next_overflow     = 1'b1;
          end else begin
            next_counterValue = counterValue + 16'h0001;
          end
        end
      endcase
    end
    // reinitialization wins over counting; it also marks an overflow event
    if ((slaveModeSelect == `TSMIE_SM_RESET) && trigRise) begin
      next_counterValue = 16'h0000;
      next_overflow     = 1'b1;
    end
  end

  assign eventNow = {brkSync, next_trigEvent, commutationLoad, channelEvent, next_overflow};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counterValue      <= 16'h0000;
      counterEnable     <= 1'b0;
      slaveTriggerInput <= 1'b0;
      trigPrev          <= 1'b0;
      encAPrev          <= 1'b0;
      encBPrev          <= 1'b0;
    end else begin
      counterValue      <= next_counterValue;
      counterEnable     <= next_counterEnable;
      slaveTriggerInput <= next_trigSel;
      trigPrev          <= slaveTriggerInput;
      encAPrev          <= encA;
      encBPrev          <= encB;
    end
  end

  // register file writes; a hardware event wins over a write-one clear
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slaveTriggerControl <= 16'h0000;
      interruptDmaEnable  <= 16'h0000;
      eventStatus         <= 8'h00;
      periodValue         <= `TSMIE_PERIOD_RST;
    end else begin
      if (apbWrite && hit(paddr, `TSMIE_ADDR_STC)) begin
        slaveTriggerControl <= pwdata[15:0] & `TSMIE_STC_MASK;
      end
      if (apbWrite && hit(paddr, `TSMIE_ADDR_IDEN)) begin
        interruptDmaEnable <= pwdata[15:0] & `TSMIE_IDEN_MASK;
      end
      if (apbWrite && hit(paddr, `TSMIE_ADDR_PERIOD)) begin
        periodValue <= pwdata[15:0];
      end
      if (apbWrite && hit(paddr, `TSMIE_ADDR_STS)) begin
        eventStatus <= (eventStatus & ~pwdata[7:0]) | eventNow;
      end else begin
        eventStatus <= eventStatus | eventNow;
      end
    end
  end

  // outputs, all registered
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq                  <= 1'b0;
      dmaRequest           <= 7'h00;
      channelCompareOutput <= 4'h0;
    end else begin
      irq <= |(eventStatus & interruptDmaEnable[`TSMIE_EV_BRK:`TSMIE_EV_OVF]);
      dmaRequest <= eventNow[`TSMIE_EV_TRIG:`TSMIE_EV_OVF] &
                    interruptDmaEnable[`TSMIE_DMA_MSB:`TSMIE_DMA_LSB];
      if (outputClearSwitchSelect) begin
        channelCompareOutput <= channelRawCompareOutput & {4{~channelOutputOffSignal}};
      end else begin
        channelCompareOutput <= channelRawCompareOutput & {4{~extSync}};
      end
    end
  end

  // read mux
  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (hit(paddr, `TSMIE_ADDR_STC)) begin
      next_prdata[15:0] = slaveTriggerControl;
    end else if (hit(paddr, `TSMIE_ADDR_IDEN)) begin
      next_prdata[15:0] = interruptDmaEnable;
    end else if (hit(paddr, `TSMIE_ADDR_STS)) begin
      next_prdata[7:0] = eventStatus;
    end else if (hit(paddr, `TSMIE_ADDR_CTRL)) begin
      next_prdata[`TSMIE_CTRL_EN_BIT] = counterEnable;
    end else if (hit(paddr, `TSMIE_ADDR_PERIOD)) begin
      next_prdata[15:0] = periodValue;
    end else if (hit(paddr, `TSMIE_ADDR_COUNT)) begin
      next_prdata[15:0] = counterValue;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // one wait state keeps pready and prdata straight from flip-flops
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & next_pslverr;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule // tsmie_slave_timer
`default_nettype wire

/* File: dv/tsmie_far_model.sv */
// far-side model: master timer links, channel 1 inputs and the external trigger pin
`timescale 1ns/10ps
`default_nettype none
module tsmie_far_model (
  input  wire logic       core_clk,             // kernel clock
  input  wire logic       rst_n,                // async reset, active low
  input  wire logic [7:0] srcLevel,             // wanted levels, bit7 external pin
  output var  logic [3:0] internalMasterSel,    // master timer links
  output var  logic       ch1EdgeDetector,      // channel 1 edge detector
  output var  logic       filteredInputOne,     // filtered input 1
  output var  logic       filteredInputTwo,     // filtered input 2
  output logic            externalTriggerInput  // external pin, asynchronous
);
  // master links come out of flops in the same clock domain, like a real master timer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {filteredInputTwo, filteredInputOne, ch1EdgeDetector, internalMasterSel} <= 7'h00;
    end else begin
      {filteredInputTwo, filteredInputOne, ch1EdgeDetector, internalMasterSel} <= srcLevel[6:0];
    end
  end
  assign externalTriggerInput = srcLevel[7];
endmodule // tsmie_far_model
`default_nettype wire

/* File: dv/tsmie_slave_timer_asserts.sv */
// port checker for the slave-mode controller and enable bank
`timescale 1ns/10ps
`default_nettype none
`include "tsmie_defs.vh"
module tsmie_slave_timer_asserts (
  input wire logic        core_clk,                // kernel clock
  input wire logic        rst_n,                   // async reset
  input wire logic        psel,                    // apb select
  input wire logic        penable,                 // apb access
  input wire logic        pwrite,                  // apb direction
  input wire logic [11:0] paddr,                   // apb address
  input wire logic [31:0] pwdata,                  // apb write data
  input wire logic [31:0] prdata,                  // apb read data
  input wire logic        pready,                  // apb ready
  input wire logic [3:0]  internalMasterSel,       // master links
  input wire logic        ch1EdgeDetector,         // ch1 edge
  input wire logic        filteredInputOne,        // filtered 1
  input wire logic        filteredInputTwo,        // filtered 2
  input wire logic [3:0]  channelRawCompareOutput, // raw outputs
  input wire logic        channelOutputOffSignal,  // off signal
  input wire logic [3:0]  channelCompareOutput,    // cleared outputs
  input wire logic [15:0] counterValue,            // counter
  input wire logic        slaveTriggerInput,       // selected trigger
  input wire logic [6:0]  dmaRequest               // dma pulses
);
  logic [6:0]  stc;
  logic [14:0] en;
  logic        wr;
  logic [7:0]  srcs;
  assign wr = psel && penable && pready && pwrite;
  assign srcs = {1'b0, filteredInputTwo, filteredInputOne, ch1EdgeDetector, internalMasterSel};
  // shadow copies let the checker know the mode and enables without seeing inside
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stc <= 7'h00;
      en <= 15'h0000;
    end else if (wr && paddr == `TSMIE_ADDR_STC) begin
      stc <= pwdata[6:0];
    end else if (wr && paddr == `TSMIE_ADDR_IDEN) begin
      en <= pwdata[14:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_src; stc[6:4] != 3'h7 |=> slaveTriggerInput == $past(srcs[stc[6:4]]); endproperty
  a_src: assert property (p_src) else $error("trigger source routing wrong");
  property p_clear;
    stc[3] |=> channelCompareOutput == $past(channelRawCompareOutput & {4{!channelOutputOffSignal}});
  endproperty
  a_clear: assert property (p_clear) else $error("output clear by off signal wrong");
  property p_rstmode;
    stc[2:0] == 3'h4 && $rose(slaveTriggerInput) |-> ##[1:2] counterValue == 16'h0000;
  endproperty
  a_rstmode: assert property (p_rstmode) else $error("reset mode did not zero counter");
  property p_susp; stc[2:0] == 3'h5 && !slaveTriggerInput |=> $stable(counterValue); endproperty
  a_susp: assert property (p_susp) else $error("counter moved while gate low");
  property p_trig;
    (stc[2:0] == 3'h5 ? $changed(slaveTriggerInput) : $rose(slaveTriggerInput)) && en[14]
      |=> dmaRequest[6];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger event without dma request");
  property p_trigger_dma_en; dmaRequest[6] |-> $past(en[14]); endproperty
  a_trigger_dma_en: assert property (p_trigger_dma_en) else $error("trigger dma while disabled");
  property p_comm; dmaRequest[5] |-> $past(en[13]); endproperty
  a_comm: assert property (p_comm) else $error("commutation dma while disabled");
  property p_chdma; |dmaRequest[4:1] |-> (dmaRequest[4:1] & ~$past(en[12:9])) == 4'h0; endproperty
  a_chdma: assert property (p_chdma) else $error("channel dma while disabled");
  property p_ovf; dmaRequest[0] |-> $past(en[8]); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow dma while disabled");
  property p_rsvd; pready && !pwrite && paddr == `TSMIE_ADDR_IDEN |-> prdata[31:15] == 17'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved enable bit read nonzero");
endmodule // tsmie_slave_timer_asserts
bind tsmie_slave_timer tsmie_slave_timer_asserts i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .internalMasterSel(internalMasterSel),
  .ch1EdgeDetector(ch1EdgeDetector), .filteredInputOne(filteredInputOne),
  .filteredInputTwo(filteredInputTwo), .channelRawCompareOutput(channelRawCompareOutput),
  .channelOutputOffSignal(channelOutputOffSignal), .channelCompareOutput(channelCompareOutput),
  .counterValue(counterValue), .slaveTriggerInput(slaveTriggerInput), .dmaRequest(dmaRequest));
`default_nettype wire

/* File: dv/tsmie_slave_timer_tb.sv */
// self-checking testbench of the slave-mode timer
`timescale 1ns/10ps
`default_nettype none
`include "tsmie_defs.vh"
module tsmie_slave_timer_tb;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [7:0] srcLevel = 0;
  logic [3:0] chEv = 0, raw = 0, ims, cco;
  logic off = 0, er, pready, pslverr, c1e, f1, f2, external_trigger_input, sti, irq;
  logic [15:0] c0, cnt;
  logic [6:0] dma;
  int mismatches = 0, cmp_count = 0;
  initial forever #2 core_clk = ~core_clk;
  tsmie_far_model i_far (.core_clk(core_clk), .rst_n(rst_n), .srcLevel(srcLevel),
    .internalMasterSel(ims), .ch1EdgeDetector(c1e), .filteredInputOne(f1),
    .filteredInputTwo(f2), .externalTriggerInput(external_trigger_input));
  tsmie_slave_timer i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internalMasterSel(ims), .ch1EdgeDetector(c1e), .filteredInputOne(f1),
    .filteredInputTwo(f2), .externalTriggerInput(external_trigger_input), .breakInput(1'b0), .encoderInA(1'b0),
    .encoderInB(1'b0), .channelEvent(chEv), .commutationLoad(1'b0),
    .channelRawCompareOutput(raw), .channelOutputOffSignal(off), .channelCompareOutput(cco),
    .counterValue(cnt), .slaveTriggerInput(sti), .irq(irq), .dmaRequest(dma));
  task summarize;
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do @(posedge core_clk); while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task waitTrig(input logic v);
    int n;
    n = 0;
    // ext pin needs the synchroniser's few cycles, master links only two
    while (sti !== v && n++ < 12) @(posedge core_clk);
    check({31'h0, v}, {31'h0, sti});
  endtask
  task t_regs;
    apb(0, `TSMIE_ADDR_STC, 0); check(0, rd);
    apb(0, `TSMIE_ADDR_IDEN, 0); check(0, rd);
    apb(1, `TSMIE_ADDR_IDEN, 32'hffffffff); apb(0, `TSMIE_ADDR_IDEN, 0); check(32'h7fff, rd);
    apb(1, `TSMIE_ADDR_STC, 32'hffffffff); apb(0, `TSMIE_ADDR_STC, 0); check(32'h7f, rd);
    apb(0, 12'h018, 0); check(1, {31'h0, er});
    apb(1, `TSMIE_ADDR_IDEN, 0); apb(1, `TSMIE_ADDR_STC, 0);
  endtask
  task t_src;
    for (int i = 0; i < 8; i++) begin
      apb(1, `TSMIE_ADDR_STC, i << 4);
      srcLevel <= 8'h01 << i; waitTrig(1);
      srcLevel <= ~(8'h01 << i); waitTrig(0);
    end
    srcLevel <= 0;
  endtask
  task t_clear;
    raw <= 4'hf; off <= 1;
    apb(1, `TSMIE_ADDR_STC, 32'h08); repeat (3) @(posedge core_clk); check(0, cco);
    off <= 0; repeat (3) @(posedge core_clk); check(32'hf, cco);
    off <= 1; apb(1, `TSMIE_ADDR_STC, 0); srcLevel <= 8'h80;
    repeat (8) @(posedge core_clk); check(0, cco);
    srcLevel <= 0; repeat (8) @(posedge core_clk); check(32'hf, cco);
  endtask
  task t_irq;
    apb(1, `TSMIE_ADDR_STS, 32'hff);
    apb(1, `TSMIE_ADDR_IDEN, 32'h4042); apb(1, `TSMIE_ADDR_STC, 32'h06);
    srcLevel <= 1; waitTrig(1);
    @(posedge core_clk); check(32'h40, {25'h0, dma});
    repeat (2) @(posedge core_clk); check(1, irq);
    apb(0, `TSMIE_ADDR_CTRL, 0); check(1, rd & 1);
    apb(1, `TSMIE_ADDR_IDEN, 0); repeat (2) @(posedge core_clk); check(0, irq);
    apb(1, `TSMIE_ADDR_IDEN, 32'h42); repeat (2) @(posedge core_clk); check(1, irq);
    apb(1, `TSMIE_ADDR_STS, 32'h40); repeat (2) @(posedge core_clk); check(0, irq);
    chEv <= 4'h1; @(posedge core_clk); chEv <= 0;
    repeat (3) @(posedge core_clk); check(1, irq);
    apb(1, `TSMIE_ADDR_STS, 32'h02); repeat (2) @(posedge core_clk); check(0, irq);
    srcLevel <= 0; waitTrig(0);
  endtask
  task t_modes;
    apb(1, `TSMIE_ADDR_IDEN, 32'h4100); apb(1, `TSMIE_ADDR_CTRL, 1); apb(1, `TSMIE_ADDR_STC, 4);
    srcLevel <= 1; waitTrig(1); repeat (2) @(posedge core_clk); check(1, cnt < 16'h5);
    srcLevel <= 0; waitTrig(0); apb(1, `TSMIE_ADDR_STC, 5);
    @(posedge core_clk);
    c0 = cnt; repeat (5) @(posedge core_clk); check(c0, cnt);
    srcLevel <= 1; waitTrig(1); repeat (4) @(posedge core_clk); check(1, cnt != c0);
    srcLevel <= 0; apb(1, `TSMIE_ADDR_CTRL, 0); apb(1, `TSMIE_ADDR_STC, 7); waitTrig(0);
    c0 = cnt; apb(1, `TSMIE_ADDR_CTRL, 1);
    repeat (3) begin
      srcLevel <= 1; waitTrig(1); srcLevel <= 0; waitTrig(0);
    end
    repeat (2) @(posedge core_clk); check(c0 + 16'h3, cnt);
    apb(1, `TSMIE_ADDR_CTRL, 0); apb(1, `TSMIE_ADDR_STC, 0); c0 = cnt;
    srcLevel <= 1; waitTrig(1); srcLevel <= 0; waitTrig(0); check(c0, cnt);
  endtask
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    t_regs;
    t_src;
    t_clear;
    t_irq;
    t_modes;
    summarize;
  end
endmodule // tsmie_slave_timer_tb
`default_nettype wire
